// ### core/fdi_consts.svh
// Constants of the fault diagnosis and group-fault lamp block.
// Assumes a 40 MHz APB clock and ten output channels in two groups of five.
`ifndef FDI_CONSTS_SVH
`define FDI_CONSTS_SVH
`define FDI_NCH 10
`define FDI_NGRP 2
`define FDI_GRP_SIZE 5
`define FDI_ADDR_W 8
// Register byte offsets.
`define FDI_OFS_PARAM 8'h00
`define FDI_OFS_ACK 8'h04
`define FDI_OFS_WB_STAT 8'h08
`define FDI_OFS_SG_STAT 8'h0C
`define FDI_OFS_MOD_STAT 8'h10
`define FDI_OFS_IRQ_STAT 8'h14
`define FDI_OFS_IRQ_MASK 8'h18
`define FDI_OFS_LAST_MSG 8'h1C
// PARAM fields.
`define FDI_PRM_WB_LSB 0
`define FDI_PRM_APP_LSB 12
`define FDI_PRM_REDUNDANT 16
`define FDI_PRM_LOADDIAG_LSB 20
`define FDI_APP_SAFETY 4'h5
`define FDI_APP_HIGH_AVAIL 4'h6
// ACK fields: channels in [9:0], groups in [21:20], module and passivation.
`define FDI_ACK_GRP_LSB 20
`define FDI_ACK_MOD 24
`define FDI_ACK_PASSIV 25
// Module fault bits.
`define FDI_MOD_NOPARAM 0
`define FDI_MOD_BADPARAM 1
`define FDI_MOD_INTSUPPLY 2
`define FDI_MOD_SHORTSUP 3
`define FDI_NMOD 4
// MOD_STAT extra fields.
`define FDI_MST_SUPLOCK 4
`define FDI_MST_PASSIV 5
`define FDI_MST_GRP_LSB 8
`define FDI_MST_LAMP_LSB 16
// IRQ bits.
`define FDI_IRQ_CHAN 0
`define FDI_IRQ_GRP 1
`define FDI_IRQ_MOD 2
`define FDI_NIRQ 3
// Lamp flash half period.
`define FDI_CLK_NS 25
`define FDI_FLASH_HALF_NS 250000000
`define FDI_FLASH_HALF_CYC (`FDI_FLASH_HALF_NS / `FDI_CLK_NS)
`endif

// ### core/fdi_pkg.sv
// Types shared by the fault diagnosis block.
// Assumes nothing beyond the constants header.
package fdi_pkg;
   typedef enum logic [1:0] {LAMP_DARK, LAMP_LIT, LAMP_FLASH} fdi_lamp_t;
   typedef enum logic [1:0] {SCOPE_NONE, SCOPE_CHAN, SCOPE_GRP, SCOPE_MOD} fdi_scope_t;
   typedef enum logic [3:0] {MSG_NONE, MSG_WIRE_BREAK, MSG_SHORT_GND, MSG_SHORT_SUP,
      MSG_PARAM_NONE, MSG_PARAM_BAD, MSG_INT_SUPPLY, MSG_LOAD_VOLT} fdi_msg_t;
endpackage

// ### core/fdi_fault_latch.sv
// Vector of fault latches: set on an evaluated fault, cleared by acknowledge once gone.
// Assumes raw, eval and ack come from logic on pclk.
`timescale 1ns/1ps
`default_nettype none
module fdi_fault_latch #(
   parameter int W = 10
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Fault inputs
   input wire logic [W-1:0] raw,
   input wire logic [W-1:0] eval,
   input wire logic [W-1:0] ack,
   // State
   output logic [W-1:0] latched,
   output logic [W-1:0] present,
   output logic [W-1:0] waiting,
   output logic [W-1:0] rose
);
   logic [W-1:0] latched_r;
   logic [W-1:0] latched_nxt;
   logic [W-1:0] present_r;
   logic [W-1:0] present_nxt;

   // A fault is only judged while it can be evaluated; otherwise the last verdict holds.
   always_comb
   begin
      present_nxt = (eval & raw) | (~eval & present_r);
      latched_nxt = (eval & raw) | (latched_r & ~(ack & ~present_r));
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         latched_r <= '0;
         present_r <= '0;
      end
      else
      begin
         latched_r <= latched_nxt;
         present_r <= present_nxt;
      end
   end

   assign latched = latched_r;
   assign present = present_r;
   assign waiting = latched_r & ~present_r;
   assign rose = latched_nxt & ~latched_r;

   a_set_latches: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> ((latched_r & $past(eval & raw)) == $past(eval & raw)))
      else $error("Evaluated fault was not latched.");
   a_clear_cause: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> ((~latched_r & $past(latched_r) & ~$past(ack & ~present_r)) == '0))
      else $error("Fault latch cleared without acknowledge of a gone fault.");
endmodule
`default_nettype wire

// ### core/fdi_top.sv
// Fault collection, scoping, latching and group-fault lamp, with an APB register file.
// Assumes fault sense pins are asynchronous; light_test comes from logic on pclk.
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fdi_consts.svh"
module fdi_top #(
   parameter int NCH = `FDI_NCH,
   parameter int FLASH_HALF_CYC = `FDI_FLASH_HALF_CYC
) (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`FDI_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Fault sensing pins
   input wire logic [NCH-1:0] out_on,
   input wire logic [NCH-1:0] wire_break_sense,
   input wire logic [NCH-1:0] short_gnd_sense,
   input wire logic short_sup_sense,
   input wire logic [`FDI_NGRP-1:0] load_volt_ok,
   input wire logic first_supply_input_ok,
   // Test sequencer
   input wire logic [NCH-1:0] light_test,
   // Indication
   output logic group_fault_lamp,
   output logic irq
);
   import fdi_pkg::*;

   localparam int NS = 3 * NCH + `FDI_NGRP + 2;
   localparam int CW = $clog2(FLASH_HALF_CYC + 1);

   function automatic logic [3:0] first_set(input logic [15:0] v);
      first_set = 4'h0;
      for (int i = 15; i >= 0; i--)
      begin
         if (v[i])
         begin
            first_set = 4'(i);
         end
      end
   endfunction

   // Pin synchronisers; the first stage feeds only the second.
   logic [NS-1:0] sync1_r;
   logic [NS-1:0] sync2_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // The supply and load-voltage bits idle at ok, so a reset raises no false fault.
         sync1_r <= {{(NS-`FDI_NGRP-1){1'b0}}, {(`FDI_NGRP+1){1'b1}}};
         sync2_r <= {{(NS-`FDI_NGRP-1){1'b0}}, {(`FDI_NGRP+1){1'b1}}};
      end
      else
      begin
         sync1_r <= {out_on, wire_break_sense, short_gnd_sense, short_sup_sense,
            load_volt_ok, first_supply_input_ok};
         sync2_r <= sync1_r;
      end
   end
   logic [NCH-1:0] s_out_on;
   logic [NCH-1:0] s_wb;
   logic [NCH-1:0] s_sg;
   logic s_ss;
   logic [`FDI_NGRP-1:0] s_load_ok;
   logic s_sup_ok;
   assign {s_out_on, s_wb, s_sg, s_ss, s_load_ok, s_sup_ok} = sync2_r;

   // Bus and register state.
   logic [31:0] param_r, param_nxt;
   logic loaded_r, loaded_nxt;
   logic [`FDI_NIRQ-1:0] irq_mask_r, irq_mask_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic wr_take, rd_take;
   logic [31:0] rd_val;
   logic mapped;

   // Fault state.
   logic [NCH-1:0] wb_lat, wb_pres, wb_wait, wb_rose;
   logic [NCH-1:0] sg_lat, sg_pres, sg_wait, sg_rose;
   logic [`FDI_NGRP-1:0] gr_lat, gr_pres, gr_wait, gr_rose;
   logic [`FDI_NMOD-1:0] md_lat, md_pres, md_wait, md_rose, md_raw;
   logic [NCH-1:0] eval_out, wb_en, ack_ch;
   logic [`FDI_NGRP-1:0] ack_gr, load_en;
   logic [3:0] app;
   logic app_ok, redundant, ack_mod, ack_pass;
   logic sup_lock_r, sup_lock_nxt;
   logic passiv_r, passiv_nxt;
   logic [`FDI_NIRQ-1:0] irq_stat_r, irq_stat_nxt, irq_ev;
   logic [11:0] last_r, last_nxt;
   logic irq_r, irq_nxt;

   // Lamp state.
   fdi_lamp_t lamp_r, lamp_nxt;
   logic lamp_out_r, lamp_out_nxt;
   logic [CW-1:0] flash_cnt_r, flash_cnt_nxt;
   logic flash_tick;

   assign wr_take = psel && penable && pready_r && pwrite;
   assign rd_take = psel && penable && pready_r && !pwrite;
   assign app = param_r[`FDI_PRM_APP_LSB +: 4];
   assign app_ok = (app == `FDI_APP_SAFETY) || (app == `FDI_APP_HIGH_AVAIL);
   assign redundant = param_r[`FDI_PRM_REDUNDANT];
   assign wb_en = param_r[`FDI_PRM_WB_LSB +: NCH];
   assign load_en = param_r[`FDI_PRM_LOADDIAG_LSB +: `FDI_NGRP];
   assign eval_out = s_out_on | light_test;
   assign ack_ch = (wr_take && paddr == `FDI_OFS_ACK) ? pwdata[NCH-1:0] : '0;
   assign ack_gr = (wr_take && paddr == `FDI_OFS_ACK) ? pwdata[`FDI_ACK_GRP_LSB +: 2] : '0;
   assign ack_mod = wr_take && paddr == `FDI_OFS_ACK && pwdata[`FDI_ACK_MOD];
   assign ack_pass = wr_take && paddr == `FDI_OFS_ACK && pwdata[`FDI_ACK_PASSIV];

   always_comb
   begin
      md_raw = '0;
      md_raw[`FDI_MOD_NOPARAM] = !loaded_r;
      md_raw[`FDI_MOD_BADPARAM] = loaded_r && !app_ok;
      md_raw[`FDI_MOD_INTSUPPLY] = !s_sup_ok;
      // Only the redundant short to supply may be acknowledged away.
      md_raw[`FDI_MOD_SHORTSUP] = s_ss && redundant && app == `FDI_APP_SAFETY;
   end

   fdi_fault_latch #(.W(NCH)) u_wb (
      .pclk(pclk), .presetn(presetn),
      .raw(s_wb & {NCH{app_ok}}), .eval(eval_out & wb_en), .ack(ack_ch),
      .latched(wb_lat), .present(wb_pres), .waiting(wb_wait), .rose(wb_rose));
   fdi_fault_latch #(.W(NCH)) u_sg (
      .pclk(pclk), .presetn(presetn),
      .raw(s_sg & {NCH{app_ok}}), .eval(eval_out), .ack(ack_ch),
      .latched(sg_lat), .present(sg_pres), .waiting(sg_wait), .rose(sg_rose));
   fdi_fault_latch #(.W(`FDI_NGRP)) u_grp (
      .pclk(pclk), .presetn(presetn),
      .raw(~s_load_ok), .eval(load_en), .ack(ack_gr),
      .latched(gr_lat), .present(gr_pres), .waiting(gr_wait), .rose(gr_rose));
   fdi_fault_latch #(.W(`FDI_NMOD)) u_mod (
      .pclk(pclk), .presetn(presetn),
      .raw(md_raw), .eval({`FDI_NMOD{1'b1}}), .ack({`FDI_NMOD{ack_mod}}),
      .latched(md_lat), .present(md_pres), .waiting(md_wait), .rose(md_rose));

   // Fault bookkeeping: lock, passivation, interrupts and last message.
   always_comb
   begin
      sup_lock_nxt = sup_lock_r | (s_ss && !redundant && app == `FDI_APP_SAFETY);
      passiv_nxt = (|md_rose) || (sup_lock_nxt && !sup_lock_r)
         || (passiv_r && !(ack_pass && !(|md_pres) && !sup_lock_r));
      irq_ev = {(|md_rose) || (sup_lock_nxt && !sup_lock_r), |gr_rose, |(wb_rose | sg_rose)};
      // A read clears only the bits it returned; an event landing meanwhile survives.
      irq_stat_nxt = irq_ev | (irq_stat_r
         & ~((rd_take && paddr == `FDI_OFS_IRQ_STAT) ? prdata_r[`FDI_NIRQ-1:0] : '0));
      irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
      last_nxt = last_r;
      // Module messages outrank group ones, which outrank channel ones.
      if (sup_lock_nxt && !sup_lock_r)
      begin
         last_nxt = {4'h0, 4'(MSG_SHORT_SUP), 2'(SCOPE_MOD), 2'h0};
      end
      else if (|md_rose)
      begin
         unique case (first_set(16'(md_rose)))
            4'h0: last_nxt = {4'h0, 4'(MSG_PARAM_NONE), 2'(SCOPE_MOD), 2'h0};
            4'h1: last_nxt = {4'h0, 4'(MSG_PARAM_BAD), 2'(SCOPE_MOD), 2'h0};
            4'h2: last_nxt = {4'h0, 4'(MSG_INT_SUPPLY), 2'(SCOPE_MOD), 2'h0};
            default: last_nxt = {4'h0, 4'(MSG_SHORT_SUP), 2'(SCOPE_MOD), 2'h0};
         endcase
      end
      else if (|gr_rose)
      begin
         last_nxt = {first_set(16'(gr_rose)), 4'(MSG_LOAD_VOLT), 2'(SCOPE_GRP), 2'h0};
      end
      else if (|sg_rose)
      begin
         last_nxt = {first_set(16'(sg_rose)), 4'(MSG_SHORT_GND), 2'(SCOPE_CHAN), 2'h0};
      end
      else if (|wb_rose)
      begin
         last_nxt = {first_set(16'(wb_rose)), 4'(MSG_WIRE_BREAK), 2'(SCOPE_CHAN), 2'h0};
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sup_lock_r <= 1'b0;
         passiv_r <= 1'b0;
         irq_stat_r <= '0;
         irq_r <= 1'b0;
         last_r <= 12'h000;
      end
      else
      begin
         sup_lock_r <= sup_lock_nxt;
         passiv_r <= passiv_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_r <= irq_nxt;
         last_r <= last_nxt;
      end
   end

   // Lamp: lit on any standing fault, otherwise flashing while anything awaits acknowledge.
   always_comb
   begin
      flash_tick = (flash_cnt_r == CW'(FLASH_HALF_CYC - 1));
      flash_cnt_nxt = flash_tick ? '0 : flash_cnt_r + CW'(1);
      if ((|wb_pres) || (|sg_pres) || (|gr_pres) || (|md_pres) || sup_lock_r)
      begin
         lamp_nxt = LAMP_LIT;
      end
      else if ((|wb_wait) || (|sg_wait) || (|gr_wait) || (|md_wait) || passiv_r)
      begin
         lamp_nxt = LAMP_FLASH;
      end
      else
      begin
         lamp_nxt = LAMP_DARK;
      end
      unique case (lamp_nxt)
         LAMP_LIT: lamp_out_nxt = 1'b1;
         LAMP_FLASH: lamp_out_nxt = flash_tick ? !lamp_out_r : lamp_out_r;
         LAMP_DARK: lamp_out_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lamp_r <= LAMP_DARK;
         lamp_out_r <= 1'b0;
         flash_cnt_r <= '0;
      end
      else
      begin
         lamp_r <= lamp_nxt;
         lamp_out_r <= lamp_out_nxt;
         flash_cnt_r <= flash_cnt_nxt;
      end
   end

   // APB slave: one wait-free access phase, answer prepared in the setup cycle.
   always_comb
   begin
      mapped = 1'b1;
      rd_val = 32'h0000_0000;
      unique case (paddr)
         `FDI_OFS_PARAM: rd_val = param_r;
         `FDI_OFS_ACK: rd_val = 32'h0000_0000;
         `FDI_OFS_WB_STAT: rd_val = 32'(wb_lat);
         `FDI_OFS_SG_STAT: rd_val = 32'(sg_lat);
         `FDI_OFS_MOD_STAT: rd_val = 32'(md_lat) | (32'(sup_lock_r) << `FDI_MST_SUPLOCK)
            | (32'(passiv_r) << `FDI_MST_PASSIV) | (32'(gr_lat) << `FDI_MST_GRP_LSB)
            | (32'(lamp_r) << `FDI_MST_LAMP_LSB);
         `FDI_OFS_IRQ_STAT: rd_val = 32'(irq_stat_r);
         `FDI_OFS_IRQ_MASK: rd_val = 32'(irq_mask_r);
         `FDI_OFS_LAST_MSG: rd_val = 32'(last_r);
         default: mapped = 1'b0;
      endcase
      pready_nxt = psel && !penable;
      prdata_nxt = (psel && !penable && !pwrite) ? rd_val : prdata_r;
      pslverr_nxt = psel && !penable && !mapped;
      param_nxt = (wr_take && paddr == `FDI_OFS_PARAM) ? pwdata : param_r;
      loaded_nxt = loaded_r || (wr_take && paddr == `FDI_OFS_PARAM);
      irq_mask_nxt = (wr_take && paddr == `FDI_OFS_IRQ_MASK) ? pwdata[`FDI_NIRQ-1:0]
         : irq_mask_r;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         param_r <= 32'h0000_0000;
         loaded_r <= 1'b0;
         irq_mask_r <= '0;
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         param_r <= param_nxt;
         loaded_r <= loaded_nxt;
         irq_mask_r <= irq_mask_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign group_fault_lamp = lamp_out_r;
   assign irq = irq_r;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_lamp_lit_fault: assert property ((|sg_pres) |=> lamp_r == LAMP_LIT)
      else $error("Lamp not lit while a fault stands.");
   a_lamp_flash_wait: assert property ((!(|sg_pres) && !(|wb_pres) && !(|gr_pres)
      && !(|md_pres) && !sup_lock_r && (|sg_wait)) |=> lamp_r == LAMP_FLASH)
      else $error("Lamp not flashing while a cleared fault awaits acknowledge.");
   a_lamp_dark_clean: assert property ((lamp_r == LAMP_DARK) |-> $past(!(|sg_lat)
      && !(|wb_lat) && !(|gr_lat) && !(|md_lat) && !passiv_r))
      else $error("Lamp dark while a fault is latched.");
   a_passiv_hold: assert property ((passiv_r && !ack_pass) |=> passiv_r)
      else $error("Passivation dropped without acknowledge.");
   a_sup_lock_sticky: assert property (sup_lock_r |=> sup_lock_r [*8])
      else $error("Short to supply lock released before reset.");
   a_sup_only_app5: assert property ($rose(sup_lock_r) |-> $past(app) == 4'h5)
      else $error("Short to supply raised outside application 5.");
   a_noparam_msg: assert property (!loaded_r |-> ##2 md_lat[`FDI_MOD_NOPARAM])
      else $error("Missing parameter message not raised.");
   a_badparam_msg: assert property ((loaded_r && !app_ok)
      |=> md_lat[`FDI_MOD_BADPARAM])
      else $error("Incorrect parameter message not raised.");
   a_supply_msg: assert property (!s_sup_ok |=> md_lat[`FDI_MOD_INTSUPPLY])
      else $error("Internal supply message not raised.");
   a_wb_gated: assert property ($rose(|wb_lat) |-> $past(|(eval_out & wb_en)))
      else $error("Wire break latched without evaluation or enable.");
   a_sg_gated: assert property ($rose(|sg_lat)
      |-> $past(|eval_out) && $past(app_ok))
      else $error("Short to ground latched while not evaluated.");
   a_grp_scope: assert property ((|gr_rose) && !(|md_rose)
      && !(sup_lock_nxt && !sup_lock_r) |=> last_r[3:2] == 2'(SCOPE_GRP))
      else $error("Load voltage message not scoped to its group.");
endmodule
`default_nettype wire

// ### tb/fdi_plant.sv
// Actuator-side model: turns injected wiring faults into fault sense levels.
// Assumes injections change just after rising edges of pclk.
`timescale 1ns/1ps
`default_nettype none
module fdi_plant (
   // Clock
   input wire logic pclk,
   // Injected faults
   input wire logic [9:0] inj_wb,
   input wire logic [9:0] inj_sg,
   input wire logic inj_sup,
   // Sense levels
   output logic [9:0] wb_sense,
   output logic [9:0] sg_sense,
   output logic sup_sense
);
   initial
   begin
      wb_sense = 10'h000;
      sg_sense = 10'h000;
      sup_sense = 1'b0;
   end
   // A real load shows its fault whether the output is on or not, so gating is left
   // entirely to the block.
   always @(posedge pclk)
   begin
      wb_sense <= inj_wb;
      sg_sense <= inj_sg;
      sup_sense <= inj_sup;
   end
endmodule
`default_nettype wire

// ### tb/fault_diag_indicator_tb_top.sv
// Testbench: APB master, read checker fed by a queue of notes, fault scenarios.
// Assumes fdi_top, fdi_plant and the constants header are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "fdi_consts.svh"
module fault_diag_indicator_tb_top;
   import fdi_pkg::*;
   typedef struct packed {logic [31:0] v; logic [31:0] m; logic e;} fdi_note_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lamp, irq;
   logic inj_sup, sup_sense, supply_ok, lamp_was;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, seed;
   logic [9:0] out_on, light_test, inj_wb, inj_sg, wb_sense, sg_sense, en, s;
   logic [1:0] load_ok;
   fdi_note_t q[$];
   fdi_note_t note;
   int n_fail = 0;
   int tests_run = 0;
   fdi_top #(.NCH(10), .FLASH_HALF_CYC(4)) i_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .out_on(out_on),
      .wire_break_sense(wb_sense), .short_gnd_sense(sg_sense), .short_sup_sense(sup_sense),
      .load_volt_ok(load_ok), .first_supply_input_ok(supply_ok), .light_test(light_test),
      .group_fault_lamp(lamp), .irq(irq));
   fdi_plant i_plant (.pclk(pclk), .inj_wb(inj_wb), .inj_sg(inj_sg), .inj_sup(inj_sup),
      .wb_sense(wb_sense), .sg_sense(sg_sense), .sup_sense(sup_sense));
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction
   function automatic logic [31:0] prm(input logic [9:0] e, input logic [3:0] app);
      return 32'h0030_0000 | {16'h0000, app, 2'h0, e};
   endfunction
   task automatic fail(input string msg);
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Starts with an edge so two transfers never assign psel in one time step.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
         fail("no ready");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m,
      input logic e);
      q.push_back('{v, m, e});
      apb(1'b0, a, 32'h0000_0000);
   endtask
   task automatic cmp_rd(input fdi_note_t n);
      tests_run++;
      if ((prdata & n.m) !== (n.v & n.m) || pslverr !== n.e)
         fail("read data or error flag");
   endtask
   // Pins are looked at on the falling edge, where the design's updates have landed.
   task automatic chk_pin(input logic which, input logic exp);
      @(negedge pclk);
      tests_run++;
      if ((which ? irq : lamp) !== exp)
         fail("lamp or interrupt pin");
   endtask
   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      wt(6);
      presetn <= 1'b1;
      wt(5);
   endtask
   always @(posedge pclk)
   begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
      begin
         if (q.size() == 0)
            fail("read without note");
         else
         begin
            note = q.pop_front();
            cmp_rd(note);
         end
      end
   end
   initial
   begin
      #(25 * 20000);
      fail("timeout");
      tally_and_finish();
   end
   initial
   begin
      {presetn, psel, penable, pwrite, inj_sup} = 5'b00000;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      {out_on, light_test, inj_wb, inj_sg} = 40'h0;
      load_ok = 2'b11;
      supply_ok = 1'b1;
      seed = 32'hF690029C;
      wt(6);
      presetn <= 1'b1;
      wt(5);
      rd(`FDI_OFS_MOD_STAT, 32'h0001_0021, '1, 1'b0);
      rd(`FDI_OFS_IRQ_STAT, 32'h0000_0004, '1, 1'b0);
      rd(`FDI_OFS_IRQ_STAT, 32'h0000_0000, '1, 1'b0);
      rd(8'h20, 32'h0000_0000, '1, 1'b1);
      apb(1'b1, `FDI_OFS_PARAM, prm(10'h3FF, 4'h5));
      wt(4);
      rd(`FDI_OFS_MOD_STAT, 32'h0002_0021, '1, 1'b0);
      apb(1'b1, `FDI_OFS_ACK, 32'h0100_0000);
      rd(`FDI_OFS_MOD_STAT, 32'h0002_0020, '1, 1'b0);
      apb(1'b1, `FDI_OFS_ACK, 32'h0200_0000);
      rd(`FDI_OFS_MOD_STAT, 32'h0000_0000, '1, 1'b0);
      chk_pin(1'b0, 1'b0);
      apb(1'b1, `FDI_OFS_IRQ_MASK, 32'h0000_0007);
      rd(`FDI_OFS_IRQ_MASK, 32'h0000_0007, '1, 1'b0);
      for (int app = 5; app < 7; app++)
      begin
         apb(1'b1, `FDI_OFS_PARAM, prm(10'h3FF, app[3:0]));
         inj_sg <= 10'h008;
         wt(8);
         rd(`FDI_OFS_SG_STAT, 32'h0000_0000, '1, 1'b0);
         out_on <= 10'h008;
         wt(8);
         rd(`FDI_OFS_SG_STAT, 32'h0000_0008, '1, 1'b0);
         rd(`FDI_OFS_LAST_MSG, 32'h0000_0324, 32'h0000_0FFC, 1'b0);
         rd(`FDI_OFS_MOD_STAT, 32'h0001_0000, 32'h0003_0000, 1'b0);
         chk_pin(1'b0, 1'b1);
         chk_pin(1'b1, 1'b1);
         rd(`FDI_OFS_IRQ_STAT, 32'h0000_0001, '1, 1'b0);
         wt(2);
         chk_pin(1'b1, 1'b0);
         wt(1);
         inj_sg <= 10'h000;
         wt(8);
         rd(`FDI_OFS_MOD_STAT, 32'h0002_0000, 32'h0003_0000, 1'b0);
         @(negedge pclk);
         lamp_was = lamp;
         wt(4);
         chk_pin(1'b0, !lamp_was);
         apb(1'b1, `FDI_OFS_ACK, 32'h0000_0008);
         wt(3);
         out_on <= 10'h000;
         rd(`FDI_OFS_SG_STAT, 32'h0000_0000, '1, 1'b0);
         rd(`FDI_OFS_MOD_STAT, 32'h0000_0000, '1, 1'b0);
      end
      seed = xs(seed);
      en = seed[9:0];
      s = seed[25:16];
      apb(1'b1, `FDI_OFS_PARAM, prm(en, 4'h5));
      inj_wb <= s;
      wt(8);
      rd(`FDI_OFS_WB_STAT, 32'h0000_0000, '1, 1'b0);
      light_test <= 10'h3FF;
      wt(8);
      rd(`FDI_OFS_WB_STAT, {22'h0, s & en}, '1, 1'b0);
      inj_wb <= 10'h000;
      wt(8);
      light_test <= 10'h000;
      apb(1'b1, `FDI_OFS_ACK, 32'h0000_03FF);
      rd(`FDI_OFS_WB_STAT, 32'h0000_0000, '1, 1'b0);
      rd(`FDI_OFS_IRQ_STAT, {31'h0, |(s & en)}, '1, 1'b0);
      apb(1'b1, `FDI_OFS_IRQ_MASK, 32'h0000_0000);
      load_ok <= 2'b01;
      wt(8);
      rd(`FDI_OFS_MOD_STAT, 32'h0001_0200, 32'h0003_0300, 1'b0);
      rd(`FDI_OFS_LAST_MSG, 32'h0000_0178, 32'h0000_0FFC, 1'b0);
      chk_pin(1'b1, 1'b0);
      apb(1'b1, `FDI_OFS_IRQ_MASK, 32'h0000_0007);
      chk_pin(1'b1, 1'b1);
      rd(`FDI_OFS_IRQ_STAT, 32'h0000_0002, '1, 1'b0);
      load_ok <= 2'b11;
      wt(8);
      apb(1'b1, `FDI_OFS_ACK, 32'h0020_0000);
      rd(`FDI_OFS_MOD_STAT, 32'h0000_0000, '1, 1'b0);
      apb(1'b1, `FDI_OFS_PARAM, prm(10'h3FF, 4'h6));
      inj_sup <= 1'b1;
      wt(8);
      rd(`FDI_OFS_MOD_STAT, 32'h0000_0000, '1, 1'b0);
      apb(1'b1, `FDI_OFS_PARAM, prm(10'h3FF, 4'h3));
      wt(4);
      rd(`FDI_OFS_MOD_STAT, 32'h0001_0022, 32'h0003_0022, 1'b0);
      apb(1'b1, `FDI_OFS_PARAM, prm(10'h3FF, 4'h5));
      wt(8);
      rd(`FDI_OFS_MOD_STAT, 32'h0001_0030, 32'h0003_0030, 1'b0);
      inj_sup <= 1'b0;
      supply_ok <= 1'b0;
      wt(8);
      rd(`FDI_OFS_MOD_STAT, 32'h0000_0004, 32'h0000_0004, 1'b0);
      supply_ok <= 1'b1;
      wt(8);
      apb(1'b1, `FDI_OFS_ACK, 32'h0100_0000);
      apb(1'b1, `FDI_OFS_ACK, 32'h0200_0000);
      wt(2);
      rd(`FDI_OFS_MOD_STAT, 32'h0000_0010, 32'h0000_0010, 1'b0);
      apb(1'b1, `FDI_OFS_PARAM, prm(10'h3FF, 4'h5) | 32'h0001_0000);
      inj_sup <= 1'b1;
      wt(8);
      rd(`FDI_OFS_MOD_STAT, 32'h0000_0018, 32'h0000_0018, 1'b0);
      inj_sup <= 1'b0;
      do_reset();
      rd(`FDI_OFS_MOD_STAT, 32'h0001_0021, '1, 1'b0);
      wt(2);
      tally_and_finish();
   end
endmodule
`default_nettype wire
